// File: hdl/sltr_defs.svh
`ifndef SLTR_DEFS_SVH
`define SLTR_DEFS_SVH

// ****************************************************************
// command opcodes
// ****************************************************************
`define SLTR_OP_PL_RD     8'hfc
`define SLTR_OP_PL_RD4    8'he2
`define SLTR_OP_PL_PROG   8'hfd
`define SLTR_OP_PL_PROG4  8'he3
`define SLTR_OP_PL_ERASE  8'he4
`define SLTR_OP_DL_RD     8'hfa
`define SLTR_OP_DL_RD4    8'he0
`define SLTR_OP_DL_WR     8'hfb
`define SLTR_OP_DL_WR4    8'he1
`define SLTR_OP_TP_NVPROG 8'h43
`define SLTR_OP_TP_VWR    8'h4a
`define SLTR_OP_TP_RD     8'h41
`define SLTR_OP_OTP_RD    8'h4b
`define SLTR_OP_OTP_PROG  8'h42

// ****************************************************************
// values, sizes and field positions
// ****************************************************************
`define SLTR_LOCK_OPEN    8'hff
`define SLTR_LOCK_SHUT    8'h00
`define SLTR_PL_FACTORY   1'b1
`define SLTR_DL_DEFAULT   1'b0
`define SLTR_TP_FACTORY   8'h00
`define SLTR_UNDEF_BYTE   8'hff
`define SLTR_SECTORS      256
`define SLTR_SECT_MSB     25
`define SLTR_SECT_LSB     18
`define SLTR_OTP_BYTES    1024
`define SLTR_OTP_LIMIT    32'h0000_0400
`define SLTR_OTP_LOCK_IDX 10'h010
`define SLTR_ADDR3        3'h3
`define SLTR_ADDR4        3'h4

`endif

// File: hdl/sltr_pkg.sv
package sltr_pkg;
   typedef enum logic [2:0] {
      SLTR_ST_CMD   = 3'b000,
      SLTR_ST_ADDR  = 3'b001,
      SLTR_ST_DUMMY = 3'b010,
      SLTR_ST_DATA  = 3'b011,
      SLTR_ST_IDLE  = 3'b100
   } sltr_state_e;
endpackage

// File: hdl/sltr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sltr_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= RESET_VAL;
         q_r <= RESET_VAL;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

// File: hdl/sltr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sltr_defs.svh"
// What this block does
// - Persistent lock read answers opcodes fch (3-byte) and e2h (4-byte).
// - Persistent program fdh/e3h by address width; persistent erase e4h.
// - Persistent locks are non-volatile only, factory erased to unprotected.
// - Persistent read gives 00h if protected, ffh if unprotected.
// - Dynamic lock read answers fah (3-byte) and e0h (4-byte).
// - Dynamic lock write answers fbh (3-byte) and e1h (4-byte).
// - Dynamic locks volatile only; default and access value all zeros.
// - Dynamic lock 00h means protected, ffh means unprotected.
// - Opcodes 43h program, 4ah write volatile, 41h read training pattern.
// - Non-volatile pattern ships 00h; after one program refuses further.
// - Programming the non-volatile pattern also loads the volatile one.
// - Volatile pattern writable anytime; reloads from non-volatile on reset.
// - Learning phase drives volatile pattern, msb first, all lines alike.
// - Volatile pattern 00h means no preamble is driven.
// - 1024-byte one-time area in 32 lockable 32-byte regions.
// - One-time read 4bh as fast read; out of range gives undefined.
// - One-time program 42h as page program; reprogram allowed, no erase.
// - One-time program out of range ignored, no program error.
// - One-time program in range while frozen fails, sets program error.
// - The freeze bit and the region lock bits in bytes 10h-13h guard the one-time area.
// - Persistent program refused while guard bit is zero.
// - Sector protected when persistent or dynamic lock bit is zero.
// - Freeze holds persistent locks and one-time area locked; dynamic locks stay writable.
module sltr_top
   import sltr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_n,
   input wire logic volatile_config_one_freeze,
   input wire logic persistent_lock_guard_bit,
   input wire logic hardware_reset_pulse,
   input wire logic prog_error_clear,
   output logic prog_error,
   input wire logic [7:0] sector_query,
   output logic sector_protected,
   input wire logic learn_phase,
   input wire logic learn_edge,
   output logic [3:0] learn_io,
   output logic learn_oe_n
);
   // ****************************************************************
   // pin synchronisers and edge detect
   // ****************************************************************
   logic [2:0] pins_s;
   logic sck_s, cs_n_s, si_s;
   logic sck_q_r, cs_q_r;
   logic rise, fall, cs_end;

   sltr_sync #(.W(3), .RESET_VAL(3'b010)) u_sync
   (
      .clk(clk),
      .reset_n(reset_n),
      .d({sck, cs_n, si_in}),
      .q(pins_s)
   );

   assign sck_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign si_s = pins_s[0];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sck_q_r <= 1'b0;
         cs_q_r <= 1'b1;
      end
      else
      begin
         sck_q_r <= sck_s;
         cs_q_r <= cs_n_s;
      end
   end

   assign rise = !cs_n_s && sck_s && !sck_q_r;
   assign fall = !cs_n_s && !sck_s && sck_q_r;
   assign cs_end = cs_n_s && !cs_q_r;

   // ****************************************************************
   // storage and protocol state
   // ****************************************************************
   sltr_state_e state_r, state_nxt;
   logic [7:0] cmd_r, cmd_nxt, shift_r, shift_nxt, out_r, out_nxt;
   logic [2:0] bit_r, bit_nxt, obit_r, obit_nxt, left_r, left_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic so_r, so_nxt, so_en_r, so_en_nxt;
   logic pend_prog_r, pend_prog_nxt, pend_erase_r, pend_erase_nxt;
   logic [`SLTR_SECTORS-1:0] plock_r, plock_nxt, dlock_r, dlock_nxt;
   logic [7:0] training_pattern_nonvolatile_r, training_pattern_nonvolatile_nxt, training_pattern_volatile_r, training_pattern_volatile_nxt;
   logic nv_done_r, nv_done_nxt, perr_r, perr_nxt;
   logic [7:0] otp_r [0:`SLTR_OTP_BYTES-1];
   logic otp_we;
   logic [9:0] otp_idx;
   logic [7:0] otp_wd;
   logic [7:0] byte_in;
   logic byte_done;

   assign byte_in = {shift_r[6:0], si_s};
   assign byte_done = rise && (bit_r == 3'h7);

   function automatic logic [7:0] sect(input logic [31:0] a);
      sect = a[`SLTR_SECT_MSB:`SLTR_SECT_LSB];
   endfunction

   function automatic logic [7:0] rd_byte(input logic [7:0] c,
                                          input logic [31:0] a);
      rd_byte = `SLTR_UNDEF_BYTE;
      case (c)
         `SLTR_OP_PL_RD, `SLTR_OP_PL_RD4:
            rd_byte = plock_r[sect(a)] ? `SLTR_LOCK_OPEN
                                       : `SLTR_LOCK_SHUT;
         `SLTR_OP_DL_RD, `SLTR_OP_DL_RD4:
            rd_byte = dlock_r[sect(a)] ? `SLTR_LOCK_OPEN
                                       : `SLTR_LOCK_SHUT;
         `SLTR_OP_TP_RD:
            rd_byte = training_pattern_volatile_r;
         `SLTR_OP_OTP_RD:
            if (a < `SLTR_OTP_LIMIT)
               rd_byte = otp_r[a[9:0]];
         default:
            rd_byte = `SLTR_UNDEF_BYTE;
      endcase
   endfunction

   function automatic logic [2:0] addr_len(input logic [7:0] c);
      case (c)
         `SLTR_OP_PL_RD4, `SLTR_OP_PL_PROG4, `SLTR_OP_DL_RD4,
         `SLTR_OP_DL_WR4:
            addr_len = `SLTR_ADDR4;
         `SLTR_OP_PL_RD, `SLTR_OP_PL_PROG, `SLTR_OP_DL_RD,
         `SLTR_OP_DL_WR, `SLTR_OP_OTP_RD, `SLTR_OP_OTP_PROG:
            addr_len = `SLTR_ADDR3;
         default:
            addr_len = 3'h0;
      endcase
   endfunction

   function automatic logic is_read(input logic [7:0] c);
      is_read = (c == `SLTR_OP_PL_RD) || (c == `SLTR_OP_PL_RD4) ||
                (c == `SLTR_OP_DL_RD) || (c == `SLTR_OP_DL_RD4) ||
                (c == `SLTR_OP_TP_RD) || (c == `SLTR_OP_OTP_RD);
   endfunction

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb
   begin
      logic [31:0] a;
      logic [4:0] region;
      logic [9:0] lock_idx;
      a = 32'h0;
      region = 5'h0;
      lock_idx = 10'h0;
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      shift_nxt = shift_r;
      out_nxt = out_r;
      bit_nxt = bit_r;
      obit_nxt = obit_r;
      left_nxt = left_r;
      addr_nxt = addr_r;
      so_nxt = so_r;
      so_en_nxt = so_en_r;
      pend_prog_nxt = pend_prog_r;
      pend_erase_nxt = pend_erase_r;
      plock_nxt = plock_r;
      dlock_nxt = dlock_r;
      training_pattern_nonvolatile_nxt = training_pattern_nonvolatile_r;
      training_pattern_volatile_nxt = training_pattern_volatile_r;
      nv_done_nxt = nv_done_r;
      perr_nxt = perr_r;
      otp_we = 1'b0;
      otp_idx = 10'h0;
      otp_wd = 8'h00;
      if (prog_error_clear)
         perr_nxt = 1'b0;
      if (rise)
      begin
         shift_nxt = byte_in;
         bit_nxt = bit_r + 3'h1;
      end
      if (byte_done)
      begin
         unique case (state_r)
            SLTR_ST_CMD:
            begin
               cmd_nxt = byte_in;
               addr_nxt = 32'h0;
               left_nxt = addr_len(byte_in);
               if (addr_len(byte_in) != 3'h0)
                  state_nxt = SLTR_ST_ADDR;
               else if (byte_in == `SLTR_OP_TP_RD)
               begin
                  state_nxt = SLTR_ST_DATA;
                  out_nxt = training_pattern_volatile_r;
                  obit_nxt = 3'h0;
               end
               else if (byte_in == `SLTR_OP_TP_NVPROG ||
                        byte_in == `SLTR_OP_TP_VWR)
                  state_nxt = SLTR_ST_DATA;
               else if (byte_in == `SLTR_OP_PL_ERASE)
               begin
                  state_nxt = SLTR_ST_IDLE;
                  pend_erase_nxt = 1'b1;
               end
               else
                  state_nxt = SLTR_ST_IDLE;
            end
            SLTR_ST_ADDR:
            begin
               a = {addr_r[23:0], byte_in};
               addr_nxt = a;
               left_nxt = left_r - 3'h1;
               if (left_r == 3'h1)
               begin
                  if (cmd_r == `SLTR_OP_OTP_RD)
                     state_nxt = SLTR_ST_DUMMY;
                  else if (is_read(cmd_r))
                  begin
                     state_nxt = SLTR_ST_DATA;
                     out_nxt = rd_byte(cmd_r, a);
                     obit_nxt = 3'h0;
                  end
                  else if (cmd_r == `SLTR_OP_PL_PROG ||
                           cmd_r == `SLTR_OP_PL_PROG4)
                  begin
                     state_nxt = SLTR_ST_IDLE;
                     pend_prog_nxt = 1'b1;
                  end
                  else
                     state_nxt = SLTR_ST_DATA;
               end
            end
            SLTR_ST_DUMMY:
            begin
               state_nxt = SLTR_ST_DATA;
               out_nxt = rd_byte(cmd_r, addr_r);
               obit_nxt = 3'h0;
            end
            SLTR_ST_DATA:
            begin
               unique case (cmd_r)
                  `SLTR_OP_DL_WR, `SLTR_OP_DL_WR4:
                     if (byte_in == `SLTR_LOCK_OPEN)
                        dlock_nxt[sect(addr_r)] = 1'b1;
                     else if (byte_in == `SLTR_LOCK_SHUT)
                        dlock_nxt[sect(addr_r)] = 1'b0;
                  `SLTR_OP_TP_NVPROG:
                     if (nv_done_r)
                        perr_nxt = 1'b1;
                     else
                     begin
                        training_pattern_nonvolatile_nxt = byte_in;
                        nv_done_nxt = 1'b1;
                        training_pattern_volatile_nxt = byte_in;
                     end
                  `SLTR_OP_TP_VWR:
                     training_pattern_volatile_nxt = byte_in;
                  `SLTR_OP_OTP_PROG:
                  begin
                     addr_nxt = addr_r + 32'h1;
                     region = addr_r[9:5];
                     lock_idx = `SLTR_OTP_LOCK_IDX + {8'h0, region[4:3]};
                     if (addr_r < `SLTR_OTP_LIMIT)
                     begin
                        if (volatile_config_one_freeze ||
                            !otp_r[lock_idx][region[2:0]])
                           perr_nxt = 1'b1;
                        else
                        begin
                           otp_we = 1'b1;
                           otp_idx = addr_r[9:0];
                           otp_wd = otp_r[addr_r[9:0]] & byte_in;
                        end
                     end
                  end
                  default:
                     state_nxt = SLTR_ST_DATA;
               endcase
            end
            SLTR_ST_IDLE:
               state_nxt = SLTR_ST_IDLE;
         endcase
      end
      if (fall && state_r == SLTR_ST_DATA && is_read(cmd_r))
      begin
         so_nxt = out_r[7];
         so_en_nxt = 1'b1;
         out_nxt = {out_r[6:0], 1'b0};
         obit_nxt = obit_r + 3'h1;
         if (obit_r == 3'h7)
         begin
            addr_nxt = addr_r + 32'h1;
            out_nxt = rd_byte(cmd_r, addr_r + 32'h1);
         end
      end
      if (cs_end)
      begin
         state_nxt = SLTR_ST_CMD;
         bit_nxt = 3'h0;
         so_en_nxt = 1'b0;
         pend_prog_nxt = 1'b0;
         pend_erase_nxt = 1'b0;
         if (pend_prog_r || pend_erase_r)
         begin
            if (!persistent_lock_guard_bit ||
                volatile_config_one_freeze)
               perr_nxt = 1'b1;
            else if (pend_erase_r)
               plock_nxt = {`SLTR_SECTORS{1'b1}};
            else
               plock_nxt[sect(addr_r)] = 1'b0;
         end
      end
      if (hardware_reset_pulse)
      begin
         dlock_nxt = {`SLTR_SECTORS{`SLTR_DL_DEFAULT}};
         training_pattern_volatile_nxt = training_pattern_nonvolatile_r;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= SLTR_ST_CMD;
         cmd_r <= 8'h00;
         shift_r <= 8'h00;
         out_r <= 8'h00;
         bit_r <= 3'h0;
         obit_r <= 3'h0;
         left_r <= 3'h0;
         addr_r <= 32'h0;
         so_r <= 1'b0;
         so_en_r <= 1'b0;
         pend_prog_r <= 1'b0;
         pend_erase_r <= 1'b0;
         plock_r <= {`SLTR_SECTORS{`SLTR_PL_FACTORY}};
         dlock_r <= {`SLTR_SECTORS{`SLTR_DL_DEFAULT}};
         training_pattern_nonvolatile_r <= `SLTR_TP_FACTORY;
         training_pattern_volatile_r <= `SLTR_TP_FACTORY;
         nv_done_r <= 1'b0;
         perr_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         shift_r <= shift_nxt;
         out_r <= out_nxt;
         bit_r <= bit_nxt;
         obit_r <= obit_nxt;
         left_r <= left_nxt;
         addr_r <= addr_nxt;
         so_r <= so_nxt;
         so_en_r <= so_en_nxt;
         pend_prog_r <= pend_prog_nxt;
         pend_erase_r <= pend_erase_nxt;
         plock_r <= plock_nxt;
         dlock_r <= dlock_nxt;
         training_pattern_nonvolatile_r <= training_pattern_nonvolatile_nxt;
         training_pattern_volatile_r <= training_pattern_volatile_nxt;
         nv_done_r <= nv_done_nxt;
         perr_r <= perr_nxt;
      end
   end

   // one-time area: set to all ones by reset_n, no erase command
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < `SLTR_OTP_BYTES; i++)
            otp_r[i] <= 8'hff;
      end
      else if (otp_we)
         otp_r[otp_idx] <= otp_wd;
   end

   // ****************************************************************
   // learning pattern and protection status
   // ****************************************************************
   logic [2:0] lbit_r, lbit_nxt;
   logic [3:0] lio_r, lio_nxt;
   logic loe_n_r, loe_n_nxt, prot_r, prot_nxt;

   always_comb
   begin
      lbit_nxt = learn_phase ? lbit_r : 3'h0;
      lio_nxt = lio_r;
      if (learn_phase && learn_edge)
      begin
         lio_nxt = {4{training_pattern_volatile_r[3'h7 - lbit_r]}};
         lbit_nxt = lbit_r + 3'h1;
      end
      loe_n_nxt = !(learn_phase && training_pattern_volatile_r != 8'h00);
      prot_nxt = !plock_r[sector_query] || !dlock_r[sector_query];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lbit_r <= 3'h0;
         lio_r <= 4'h0;
         loe_n_r <= 1'b1;
         prot_r <= 1'b0;
      end
      else
      begin
         lbit_r <= lbit_nxt;
         lio_r <= lio_nxt;
         loe_n_r <= loe_n_nxt;
         prot_r <= prot_nxt;
      end
   end

   assign so_out = so_r;
   assign so_oe_n = !so_en_r;
   assign prog_error = perr_r;
   assign sector_protected = prot_r;
   assign learn_io = lio_r;
   assign learn_oe_n = loe_n_r;
endmodule
`default_nettype wire

// File: verif/sltr_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sltr_top_chk
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si_in,
   input wire logic so_out,
   input wire logic so_oe_n,
   input wire logic volatile_config_one_freeze,
   input wire logic persistent_lock_guard_bit,
   input wire logic hardware_reset_pulse,
   input wire logic prog_error_clear,
   input wire logic prog_error,
   input wire logic [7:0] sector_query,
   input wire logic sector_protected,
   input wire logic learn_phase,
   input wire logic learn_edge,
   input wire logic [3:0] learn_io,
   input wire logic learn_oe_n
);
   // ********
   // port checks
   // ********
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_quiet;
      cs_n [*8];
   endsequence
   sequence s_hw;
      hardware_reset_pulse ##2 1'b1;
   endsequence
   property p_oe_idle;
      s_quiet |-> so_oe_n;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("so_oe_n low while deselected");
   property p_oe_cs;
      $fell(so_oe_n) |-> !cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("so_oe_n fell outside a frame");
   property p_oe_drive;
      $changed(so_out) |-> !so_oe_n;
   endproperty
   a_oe_drive: assert property (p_oe_drive)
      else $error("so_out moved while not driven");
   property p_so_edge;
      $changed(so_out) |-> !sck;
   endproperty
   a_so_edge: assert property (p_so_edge)
      else $error("so_out changed while sck high");
   property p_learn_hold;
      learn_phase && !learn_edge |=> $stable(learn_io);
   endproperty
   a_learn_hold: assert property (p_learn_hold)
      else $error("learn_io moved without an edge");
   property p_learn_off;
      !learn_phase |=> learn_oe_n;
   endproperty
   a_learn_off: assert property (p_learn_off)
      else $error("learn lines driven outside phase");
   property p_err_hold;
      prog_error && !prog_error_clear |=> prog_error;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("prog_error dropped without clear");
   property p_err_clr;
      s_quiet ##0 prog_error_clear |=> !prog_error;
   endproperty
   a_err_clr: assert property (p_err_clr)
      else $error("prog_error not cleared");
   property p_hw_prot;
      s_hw |-> sector_protected;
   endproperty
   a_hw_prot: assert property (p_hw_prot)
      else $error("sector open after hardware reset");
endmodule
bind sltr_top sltr_top_chk u_chk (.clk(clk), .reset_n(reset_n), .sck(sck),
   .cs_n(cs_n), .si_in(si_in), .so_out(so_out), .so_oe_n(so_oe_n),
   .volatile_config_one_freeze(volatile_config_one_freeze),
   .persistent_lock_guard_bit(persistent_lock_guard_bit),
   .hardware_reset_pulse(hardware_reset_pulse),
   .prog_error_clear(prog_error_clear), .prog_error(prog_error),
   .sector_query(sector_query), .sector_protected(sector_protected),
   .learn_phase(learn_phase), .learn_edge(learn_edge),
   .learn_io(learn_io), .learn_oe_n(learn_oe_n));
`default_nettype wire

// File: verif/sltr_host.sv
`timescale 1ns/1ns
`default_nettype none
module sltr_host
(
   input wire logic clk,
   output logic sck,
   output logic cs_n,
   output logic si_in,
   input wire logic so_out
);
   // ********
   // mode 0 host, sck half period 10 clk
   // ********
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si_in = 1'b0;
   end
   // rd keeps the last byte shifted in, msb first
   task automatic xfer(input logic [63:0] b, input int n,
      output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk) cs_n <= 1'b0;
      for (int i = 0; i < n * 8; i++)
      begin
         repeat (5) @(posedge clk);
         si_in <= b[63 - i];
         repeat (5) @(posedge clk);
         sck <= 1'b1;
         rd = {rd[6:0], so_out};
         repeat (10) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (10) @(posedge clk);
      cs_n <= 1'b1;
      si_in <= ~si_in;
      repeat (10) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: verif/test_sltr_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_sltr_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sck, cs_n, si, so, sp, perr, loe_n;
   logic frz = 1'b0, grd = 1'b1, hwr = 1'b0, pclr = 1'b0;
   logic lph = 1'b0, led = 1'b0;
   logic [7:0] sq = 8'h00;
   logic [7:0] r;
   logic [3:0] lio;
   int err_count = 0;
   int n_checks = 0;

   initial forever #4 clk = ~clk;

   sltr_top dut (.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
      .si_in(si), .so_out(so), .so_oe_n(), .volatile_config_one_freeze(frz),
      .persistent_lock_guard_bit(grd), .hardware_reset_pulse(hwr),
      .prog_error_clear(pclr), .prog_error(perr), .sector_query(sq),
      .sector_protected(sp), .learn_phase(lph), .learn_edge(led),
      .learn_io(lio), .learn_oe_n(loe_n));
   sltr_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .si_in(si),
      .so_out(so));

   // ********
   // helpers
   // ********
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op, input logic [31:0] a,
      input int na, input logic [7:0] d, input int nd,
      output logic [7:0] rd);
      logic [63:0] b;
      b[63 -: 8] = op;
      for (int i = 1; i < 8; i++)
         b[63 - 8 * i -: 8] = (i <= na) ? a[8 * (na - i) +: 8] : d;
      host.xfer(b, 1 + na + nd, rd);
   endtask

   task automatic prot(input logic [7:0] s, output logic [7:0] v);
      @(posedge clk) sq <= s;
      repeat (2) @(posedge clk);
      #1 v = 8'(sp);
   endtask

   task automatic clr_err;
      @(posedge clk) pclr <= 1'b1;
      @(posedge clk) pclr <= 1'b0;
      #1 chk(8'(perr), 8'h00);
   endtask

   task automatic learn(input logic [7:0] p);
      @(posedge clk) lph <= 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk) led <= 1'b1;
         @(posedge clk) led <= 1'b0;
         #1 chk(8'(lio), {4'h0, {4{p[i]}}});
         chk(8'(loe_n), 8'(p == 8'h00));
      end
      @(posedge clk) lph <= 1'b0;
   endtask

   // ********
   // scenarios
   // ********
   task automatic t_defaults;
      cmd(8'hfc, 32'h0, 3, 8'h00, 1, r);
      chk(r, 8'hff);
      cmd(8'hfa, 32'h0, 3, 8'h00, 1, r);
      chk(r, 8'h00);
      cmd(8'h41, 32'h0, 0, 8'h00, 1, r);
      chk(r, 8'h00);
      prot(8'h05, r);
      chk(r, 8'h01);
   endtask

   task automatic t_dyn;
      cmd(8'hfb, 32'h14_0000, 3, 8'hff, 1, r);
      cmd(8'he0, 32'h14_0000, 4, 8'h00, 1, r);
      chk(r, 8'hff);
      prot(8'h05, r);
      chk(r, 8'h00);
      cmd(8'he1, 32'h240_0000, 4, 8'hff, 1, r);
      prot(8'h90, r);
      chk(r, 8'h00);
      cmd(8'hfb, 32'h14_0000, 3, 8'h5a, 1, r);
      cmd(8'hfa, 32'h14_0000, 3, 8'h00, 1, r);
      chk(r, 8'hff);
      cmd(8'hfb, 32'h14_0000, 3, 8'h00, 1, r);
      cmd(8'hfa, 32'h14_0000, 3, 8'h00, 1, r);
      chk(r, 8'h00);
   endtask

   task automatic t_pers;
      cmd(8'hfb, 32'h14_0000, 3, 8'hff, 1, r);
      cmd(8'hfd, 32'h14_0000, 3, 8'h00, 0, r);
      cmd(8'hfc, 32'h14_0000, 3, 8'h00, 1, r);
      chk(r, 8'h00);
      prot(8'h05, r);
      chk(r, 8'h01);
      cmd(8'he3, 32'h240_0000, 4, 8'h00, 0, r);
      cmd(8'he2, 32'h240_0000, 4, 8'h00, 1, r);
      chk(r, 8'h00);
      cmd(8'he4, 32'h0, 0, 8'h00, 0, r);
      cmd(8'he2, 32'h240_0000, 4, 8'h00, 1, r);
      chk(r, 8'hff);
      prot(8'h05, r);
      chk(r, 8'h00);
      @(posedge clk) grd <= 1'b0;
      cmd(8'hfd, 32'h14_0000, 3, 8'h00, 0, r);
      chk(8'(perr), 8'h01);
      cmd(8'hfc, 32'h14_0000, 3, 8'h00, 1, r);
      chk(r, 8'hff);
      clr_err;
      @(posedge clk) grd <= 1'b1;
   endtask

   task automatic t_train;
      cmd(8'h4a, 32'h0, 0, 8'ha5, 1, r);
      cmd(8'h41, 32'h0, 0, 8'h00, 1, r);
      chk(r, 8'ha5);
      learn(8'ha5);
      cmd(8'h43, 32'h0, 0, 8'h34, 1, r);
      chk(8'(perr), 8'h00);
      cmd(8'h41, 32'h0, 0, 8'h00, 1, r);
      chk(r, 8'h34);
      cmd(8'h43, 32'h0, 0, 8'h12, 1, r);
      chk(8'(perr), 8'h01);
      clr_err;
      cmd(8'h4a, 32'h0, 0, 8'h00, 1, r);
      learn(8'h00);
      @(posedge clk) hwr <= 1'b1;
      @(posedge clk) hwr <= 1'b0;
      cmd(8'h41, 32'h0, 0, 8'h00, 1, r);
      chk(r, 8'h34);
      prot(8'h05, r);
      chk(r, 8'h01);
      learn(8'h34);
   endtask

   task automatic t_otp;
      @(posedge clk) grd <= 1'b0;
      cmd(8'h4b, 32'h20, 3, 8'h00, 2, r);
      chk(r, 8'hff);
      cmd(8'h42, 32'h20, 3, 8'h3c, 1, r);
      cmd(8'h4b, 32'h20, 3, 8'h00, 2, r);
      chk(r, 8'h3c);
      cmd(8'h42, 32'h20, 3, 8'hc3, 1, r);
      cmd(8'h4b, 32'h20, 3, 8'h00, 2, r);
      chk(r, 8'h00);
      cmd(8'h42, 32'h3ff, 3, 8'h5a, 1, r);
      cmd(8'h42, 32'h10, 3, 8'hfe, 1, r);
      cmd(8'h42, 32'h0, 3, 8'h00, 1, r);
      chk(8'(perr), 8'h01);
      clr_err;
      cmd(8'h42, 32'h400, 3, 8'h00, 1, r);
      chk(8'(perr), 8'h00);
      cmd(8'h4b, 32'h400, 3, 8'h00, 2, r);
      chk(r, 8'hff);
      @(posedge clk) frz <= 1'b1;
      cmd(8'h42, 32'h3ff, 3, 8'h00, 1, r);
      chk(8'(perr), 8'h01);
      cmd(8'h4b, 32'h3ff, 3, 8'h00, 2, r);
      chk(r, 8'h5a);
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_defaults;
      t_dyn;
      t_pers;
      t_train;
      t_otp;
      report_and_stop;
   end

   initial
   begin
      repeat (90000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
endmodule
`default_nettype wire
